// ==== eeru_regs.vh ====
`ifndef EERU_REGS_VH
`define EERU_REGS_VH
`define EERU_NUM_IRQ        8
`define EERU_PRIO_BITS      3
`define EERU_ENTRY_CYCLES   5'd12
`define EERU_RETURN_CYCLES  5'd12
`define EERU_CHAIN_CYCLES   5'd6
`define EERU_STACK_WORDS    4'd8
`define EERU_EXC_RETURN     32'hFFFFFFF9
`define EERU_PRIO_NMI       4'h0
`define EERU_PRIO_HARD_FAULT_EXCEPTION 4'h1
`define EERU_VEC_HARD_FAULT_EXCEPTION  6'd3
`define EERU_VEC_NMI        6'd2
`endif

// ==== eeru_stack_seq.v ====
`timescale 1ns/10ps
`include "eeru_regs.vh"
module eeru_stack_seq (
  clk_sys,
  rst_b,
  start,
  pop,
  base_addr,
  bus_fault,
  busy,
  done,
  fault,
  mem_addr,
  mem_wr,
  mem_rd
);
  input             clk_sys;
  input             rst_b;
  input             start;
  input             pop;
  input      [31:0] base_addr;
  input             bus_fault;
  output            busy;
  output            done;
  output            fault;
  output reg [31:0] mem_addr;
  output reg        mem_wr;
  output reg        mem_rd;
  reg [3:0] cnt;
  reg       run;
  reg       dir_pop;
  reg       done_r;
  reg       fault_r;
  assign busy  = run;
  assign done  = done_r;
  assign fault = fault_r;
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt <= 4'h0;
      run <= 1'b0;
      dir_pop <= 1'b0;
      done_r <= 1'b0;
      fault_r <= 1'b0;
      mem_addr <= 32'h0;
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
    end else begin
      done_r <= 1'b0;
      fault_r <= 1'b0;
      if (start && !run) begin
        run <= 1'b1;
        dir_pop <= pop;
        cnt <= 4'h0;
        mem_addr <= base_addr;
        mem_wr <= ~pop;
        mem_rd <= pop;
      end else if (run) begin
        if (bus_fault) begin
          run <= 1'b0;
          fault_r <= 1'b1;
          mem_wr <= 1'b0;
          mem_rd <= 1'b0;
        end else if (cnt == `EERU_STACK_WORDS - 4'd1) begin
          run <= 1'b0;
          done_r <= 1'b1;
          mem_wr <= 1'b0;
          mem_rd <= 1'b0;
        end else begin
          cnt <= cnt + 4'h1;
          mem_addr <= mem_addr + 32'h4;
          mem_wr <= ~dir_pop;
          mem_rd <= dir_pop;
        end
      end
    end
  end
endmodule

// ==== eeru_prio_pick.v ====
`timescale 1ns/10ps
`include "eeru_regs.vh"
module eeru_prio_pick (
  irq_pend,
  irq_en,
  irq_prio,
  prio_mask,
  any,
  win_idx,
  win_prio
);
  input  [`EERU_NUM_IRQ-1:0]                  irq_pend;
  input  [`EERU_NUM_IRQ-1:0]                  irq_en;
  input  [`EERU_NUM_IRQ*`EERU_PRIO_BITS-1:0]  irq_prio;
  input  [`EERU_PRIO_BITS-1:0]                prio_mask;
  output reg                                  any;
  output reg [2:0]                            win_idx;
  output reg [`EERU_PRIO_BITS-1:0]            win_prio;
  wire [`EERU_NUM_IRQ*`EERU_PRIO_BITS-1:0] eff;
  genvar g;
  generate
    for (g = 0; g < `EERU_NUM_IRQ; g = g + 1) begin : gp
      assign eff[g*`EERU_PRIO_BITS +: `EERU_PRIO_BITS] =
        irq_prio[g*`EERU_PRIO_BITS +: `EERU_PRIO_BITS] & prio_mask;
    end
  endgenerate
  integer i;
  always @* begin
    any = 1'b0;
    win_idx = 3'd0;
    win_prio = {`EERU_PRIO_BITS{1'b1}};
    for (i = `EERU_NUM_IRQ - 1; i >= 0; i = i - 1) begin
      if (irq_pend[i] && irq_en[i] &&
          (!any || eff[i*`EERU_PRIO_BITS +: `EERU_PRIO_BITS] <= win_prio)) begin
        any = 1'b1;
        win_idx = i[2:0];
        win_prio = eff[i*`EERU_PRIO_BITS +: `EERU_PRIO_BITS];
      end
    end
  end
endmodule

// ==== eeru_exc_unit.v ====
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "eeru_regs.vh"
module eeru_exc_unit (
  clk_sys,
  rst_b,
  irq_pend,
  irq_en,
  irq_prio,
  prio_mask,
  nmi_req,
  hard_fault_exception_req,
  thread_psp_sel,
  div_active,
  ldm_active,
  ldm_in_if_then,
  ldm_faulted,
  ldm_progress,
  ldm_base_loaded,
  ldm_base_idx,
  ldm_writeback,
  ldm_base_orig,
  ldm_base_new,
  ldm_base_in_list,
  ldm_base_last,
  ldm_base_load_val,
  cur_pc,
  link_req,
  sp_wr,
  sp_wdata,
  exc_ret_req,
  vec_rdata,
  bus_fault,
  handler_mode,
  active_vec,
  irq_ack,
  irq_ack_idx,
  mem_addr,
  mem_wr,
  mem_rd,
  vec_addr,
  vec_rd,
  fetch_req,
  fetch_pc,
  first_instr,
  state_bit,
  invalid_state_fault,
  lockup,
  lockup_prio,
  div_abandon,
  div_restart,
  continuation_progress_field,
  base_reg_value,
  base_reg_wr,
  main_stack_pointer,
  thread_stack_pointer,
  link_reg,
  sp_in_use
);
  input                                    clk_sys;
  input                                    rst_b;
  input  [`EERU_NUM_IRQ-1:0]               irq_pend;
  input  [`EERU_NUM_IRQ-1:0]               irq_en;
  input  [`EERU_NUM_IRQ*`EERU_PRIO_BITS-1:0] irq_prio;
  input  [`EERU_PRIO_BITS-1:0]             prio_mask;
  input                                    nmi_req;
  input                                    hard_fault_exception_req;
  input                                    thread_psp_sel;
  input                                    div_active;
  input                                    ldm_active;
  input                                    ldm_in_if_then;
  input                                    ldm_faulted;
  input  [3:0]                             ldm_progress;
  input                                    ldm_base_loaded;
  input  [3:0]                             ldm_base_idx;
  input                                    ldm_writeback;
  input  [31:0]                            ldm_base_orig;
  input  [31:0]                            ldm_base_new;
  input                                    ldm_base_in_list;
  input                                    ldm_base_last;
  input  [31:0]                            ldm_base_load_val;
  input  [31:0]                            cur_pc;
  input                                    link_req;
  input                                    sp_wr;
  input  [31:0]                            sp_wdata;
  input                                    exc_ret_req;
  input  [31:0]                            vec_rdata;
  input                                    bus_fault;
  output reg                               handler_mode;
  output reg [5:0]                         active_vec;
  output reg                               irq_ack;
  output reg [2:0]                         irq_ack_idx;
  output     [31:0]                        mem_addr;
  output                                   mem_wr;
  output                                   mem_rd;
  output reg [31:0]                        vec_addr;
  output reg                               vec_rd;
  output reg                               fetch_req;
  output reg [31:0]                        fetch_pc;
  output reg                               first_instr;
  output reg                               state_bit;
  output reg                               invalid_state_fault;
  output reg                               lockup;
  output reg [3:0]                         lockup_prio;
  output reg                               div_abandon;
  output reg                               div_restart;
  output reg [3:0]                         continuation_progress_field;
  output reg [31:0]                        base_reg_value;
  output reg                               base_reg_wr;
  output reg [31:0]                        main_stack_pointer;
  output reg [31:0]                        thread_stack_pointer;
  output reg [31:0]                        link_reg;
  output                                   sp_in_use;
  localparam S_IDLE  = 5'b00001;
  localparam S_ENTRY = 5'b00010;
  localparam S_RUN   = 5'b00100;
  localparam S_RET   = 5'b01000;
  localparam S_CHAIN = 5'b10000;
  reg  [4:0]  state;
  reg  [4:0]  cyc;
  reg  [31:0] ret_pc;
  reg         div_int;
  reg         from_psp;
  reg  [5:0]  prev_vec;
  reg         seq_start;
  reg         seq_pop;
  wire        seq_busy;
  wire        seq_done;
  wire        seq_fault;
  wire        irq_any;
  wire [2:0]  irq_idx;
  wire [`EERU_PRIO_BITS-1:0] irq_p;
  wire        req_any = nmi_req | hard_fault_exception_req | irq_any;
  wire [5:0]  next_vec = nmi_req ? `EERU_VEC_NMI :
                         hard_fault_exception_req ? `EERU_VEC_HARD_FAULT_EXCEPTION : {3'd2, irq_idx};
  assign sp_in_use = (handler_mode || !thread_psp_sel) ? 1'b0 : 1'b1;
  eeru_prio_pick u_pick (
    .irq_pend  (irq_pend),
    .irq_en    (irq_en),
    .irq_prio  (irq_prio),
    .prio_mask (prio_mask),
    .any       (irq_any),
    .win_idx   (irq_idx),
    .win_prio  (irq_p)
  );
  eeru_stack_seq u_seq (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .start     (seq_start),
    .pop       (seq_pop),
    .base_addr (main_stack_pointer - {26'd0, `EERU_STACK_WORDS, 2'b00}),
    .bus_fault (bus_fault),
    .busy      (seq_busy),
    .done      (seq_done),
    .fault     (seq_fault),
    .mem_addr  (mem_addr),
    .mem_wr    (mem_wr),
    .mem_rd    (mem_rd)
  );
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= S_IDLE;
      cyc <= 5'd0;
      handler_mode <= 1'b0;
      active_vec <= 6'd0;
      prev_vec <= 6'd0;
      irq_ack <= 1'b0;
      irq_ack_idx <= 3'd0;
      vec_addr <= 32'h0;
      vec_rd <= 1'b0;
      fetch_req <= 1'b0;
      fetch_pc <= 32'h0;
      first_instr <= 1'b0;
      state_bit <= 1'b1;
      invalid_state_fault <= 1'b0;
      lockup <= 1'b0;
      lockup_prio <= 4'h0;
      div_abandon <= 1'b0;
      div_restart <= 1'b0;
      div_int <= 1'b0;
      continuation_progress_field <= 4'h0;
      base_reg_value <= 32'h0;
      base_reg_wr <= 1'b0;
      main_stack_pointer <= 32'h0;
      thread_stack_pointer <= 32'h0;
      link_reg <= 32'h0;
      ret_pc <= 32'h0;
      from_psp <= 1'b0;
      seq_start <= 1'b0;
      seq_pop <= 1'b0;
    end else begin
      irq_ack <= 1'b0;
      vec_rd <= 1'b0;
      fetch_req <= 1'b0;
      first_instr <= 1'b0;
      invalid_state_fault <= 1'b0;
      div_abandon <= 1'b0;
      div_restart <= 1'b0;
      base_reg_wr <= 1'b0;
      seq_start <= 1'b0;
      if (link_req) begin
        link_reg <= {cur_pc[31:1], 1'b1};
      end
      if (sp_wr) begin
        if (sp_in_use) begin
          thread_stack_pointer <= {sp_wdata[31:2], 2'b00};
        end else begin
          main_stack_pointer <= {sp_wdata[31:2], 2'b00};
        end
      end
      if (ldm_active && !ldm_writeback && ldm_base_in_list && !ldm_base_last &&
          ldm_base_loaded) begin
        base_reg_value <= ldm_base_load_val;
        base_reg_wr <= 1'b1;
      end
      case (state)
        S_IDLE, S_RUN: begin
          if (lockup) begin
            state <= state;
          end else if (req_any && !seq_busy && !exc_ret_req) begin
            // only an nmi may preempt a running handler
            if (state == S_IDLE || (nmi_req && active_vec != `EERU_VEC_NMI)) begin
              state <= S_ENTRY;
              cyc <= 5'd1;
              ret_pc <= {cur_pc[31:1], 1'b0};
              from_psp <= sp_in_use;
              seq_start <= 1'b1;
              seq_pop <= 1'b0;
              vec_rd <= 1'b1;
              vec_addr <= {24'd0, next_vec, 2'b00};
              active_vec <= next_vec;
              irq_ack <= irq_any && !nmi_req && !hard_fault_exception_req;
              irq_ack_idx <= irq_idx;
              if (div_active) begin
                div_abandon <= 1'b1;
                div_int <= 1'b1;
              end
              if (ldm_active) begin
                if (ldm_faulted || ldm_in_if_then) begin
                  continuation_progress_field <= 4'h0;
                end else if (ldm_base_loaded) begin
                  continuation_progress_field <= ldm_base_idx;
                end else begin
                  continuation_progress_field <= ldm_progress;
                end
                base_reg_wr <= 1'b1;
                base_reg_value <= ldm_base_orig;
              end
            end
          end else if (ldm_active && ldm_writeback && !ldm_faulted) begin
            base_reg_value <= ldm_base_new;
            base_reg_wr <= 1'b1;
          end else if (state == S_RUN && exc_ret_req) begin
            prev_vec <= active_vec;
            cyc <= 5'd1;
            if (req_any) begin
              state <= S_CHAIN;
              vec_rd <= 1'b1;
              vec_addr <= {24'd0, next_vec, 2'b00};
              active_vec <= next_vec;
              irq_ack <= irq_any && !nmi_req && !hard_fault_exception_req;
              irq_ack_idx <= irq_idx;
            end else begin
              state <= S_RET;
              seq_start <= 1'b1;
              seq_pop <= 1'b1;
              fetch_req <= 1'b1;
              fetch_pc <= ret_pc;
            end
          end
        end
        S_ENTRY: begin
          cyc <= cyc + 5'd1;
          // a later redirect would miss the vector word taken in cycle 4
          if (req_any && next_vec != active_vec && cyc < 5'd3) begin
            vec_rd <= 1'b1;
            vec_addr <= {24'd0, next_vec, 2'b00};
            active_vec <= next_vec;
          end
          if (cyc == 5'd4) begin
            state_bit <= vec_rdata[0];
            fetch_req <= 1'b1;
            fetch_pc <= {vec_rdata[31:1], 1'b0};
          end
          if (seq_fault) begin
            if (hard_fault_exception_req || active_vec == `EERU_VEC_NMI) begin
              lockup <= 1'b1;
              lockup_prio <= `EERU_PRIO_NMI;
            end
          end else if (cyc == `EERU_ENTRY_CYCLES - 5'd1 && !lockup) begin
            state <= S_RUN;
            handler_mode <= 1'b1;
            link_reg <= `EERU_EXC_RETURN;
            first_instr <= 1'b1;
            invalid_state_fault <= ~state_bit;
          end
        end
        S_CHAIN: begin
          cyc <= cyc + 5'd1;
          if (cyc == 5'd2) begin
            state_bit <= vec_rdata[0];
            fetch_req <= 1'b1;
            fetch_pc <= {vec_rdata[31:1], 1'b0};
          end
          if (cyc == `EERU_CHAIN_CYCLES - 5'd1) begin
            state <= S_RUN;
            first_instr <= 1'b1;
            invalid_state_fault <= ~state_bit;
          end
        end
        S_RET: begin
          cyc <= cyc + 5'd1;
          if (seq_fault) begin
            if (prev_vec == `EERU_VEC_NMI) begin
              lockup <= 1'b1;
              lockup_prio <= `EERU_PRIO_HARD_FAULT_EXCEPTION;
            end
          end else if (cyc == `EERU_RETURN_CYCLES - 5'd1 && !lockup) begin
            state <= S_IDLE;
            handler_mode <= 1'b0;
            first_instr <= 1'b1;
            if (div_int) begin
              div_restart <= 1'b1;
              div_int <= 1'b0;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// ==== eeru_exc_monitor.sv ====
`timescale 1ns/10ps
module eeru_exc_monitor (
  input logic        clk_sys,
  input logic        rst_b,
  input logic        mem_wr,
  input logic        mem_rd,
  input logic [31:0] mem_addr,
  input logic        vec_rd,
  input logic        fetch_req,
  input logic [31:0] fetch_pc,
  input logic        first_instr,
  input logic        handler_mode,
  input logic        state_bit,
  input logic        invalid_state_fault,
  input logic        sp_in_use,
  input logic        thread_psp_sel,
  input logic [31:0] main_stack_pointer,
  input logic        lockup,
  input logic        bus_fault
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  vec_with_push_a: assert property ($rose(mem_wr) |-> $past(vec_rd))
    else $error("vector read not beside push");
  // a sequence that faults on its first word stops early, so those runs are excused
  push_eight_a: assert property ($rose(mem_wr) && !bus_fault |->
    mem_wr [*8] ##1 !mem_wr) else $error("push not eight words");
  pop_eight_a: assert property ($rose(mem_rd) && !bus_fault |->
    mem_rd [*8] ##1 !mem_rd) else $error("pop not eight words");
  push_step_a: assert property (mem_wr && $past(mem_wr) |->
    mem_addr == $past(mem_addr) + 32'h4) else $error("push address step wrong");
  entry_time_a: assert property ($rose(mem_wr) |->
    ##10 (lockup || (first_instr && handler_mode))) else $error("entry latency wrong");
  fetch_in_push_a: assert property ($rose(mem_wr) && !bus_fault |->
    ##3 (fetch_req && mem_wr)) else $error("fetch not inside push");
  fetch_in_pop_a: assert property ($rose(mem_rd) |->
    fetch_req || $past(fetch_req)) else $error("fetch not beside pop");
  bad_state_a: assert property (first_instr && handler_mode && !state_bit |->
    ##[0:1] invalid_state_fault) else $error("invalid state fault missing");
  stack_sel_a: assert property (sp_in_use == (!handler_mode && thread_psp_sel))
    else $error("wrong stack pointer in use");
  sp_align_a: assert property (main_stack_pointer[1:0] == 2'b00)
    else $error("stack pointer not word aligned");
  pc_align_a: assert property (fetch_req |-> !fetch_pc[0])
    else $error("fetch address odd");
  lockup_hold_a: assert property (lockup |=> lockup && !first_instr)
    else $error("lockup released");
endmodule

bind eeru_exc_unit eeru_exc_monitor u_mon (.clk_sys(clk_sys), .rst_b(rst_b),
  .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr), .vec_rd(vec_rd),
  .fetch_req(fetch_req), .fetch_pc(fetch_pc), .first_instr(first_instr),
  .handler_mode(handler_mode), .state_bit(state_bit),
  .invalid_state_fault(invalid_state_fault), .sp_in_use(sp_in_use),
  .thread_psp_sel(thread_psp_sel), .main_stack_pointer(main_stack_pointer),
  .lockup(lockup), .bus_fault(bus_fault));

// ==== eeru_mem_model.sv ====
`timescale 1ns/10ps
module eeru_mem_model (
  input  logic        clk_sys,
  input  logic        rst_b,
  input  logic        vec_rd,
  input  logic [31:0] vec_addr,
  input  logic        mem_wr,
  input  logic        mem_rd,
  input  logic        clr_bit0,
  input  logic        fault_cmd,
  output logic [31:0] vec_rdata,
  output logic        bus_fault
);
  logic [3:0] hold;
  // faults only while the stack sequence is on the bus
  assign bus_fault = fault_cmd && (mem_wr || mem_rd);
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      hold <= 4'h0;
      vec_rdata <= 32'hA5A5A5A5;
    end else if (vec_rd) begin
      hold <= 4'hB;
      vec_rdata <= {vec_addr[27:0], 3'h0, !clr_bit0};
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end else begin
      // no stale word once the read is over
      vec_rdata <= ~vec_rdata;
    end
  end
endmodule

// ==== eeru_exc_unit_tb.sv ====
`timescale 1ns/10ps
`include "eeru_regs.vh"
module eeru_exc_unit_tb;
  typedef struct {time t0; int lat; int ops; logic hm; logic [5:0] vec; logic sb;} eeru_note_t;
  logic        clk_sys = 1'b0, rst_b = 1'b0, nmi_req = 1'b0, hard_fault_exception_req = 1'b0;
  logic        thread_psp_sel = 1'b0, div_active = 1'b0, ldm_active = 1'b0;
  logic        ldm_in_if_then = 1'b0, ldm_faulted = 1'b0, ldm_base_loaded = 1'b0;
  logic        ldm_writeback = 1'b0, ldm_base_in_list = 1'b0, ldm_base_last = 1'b0;
  logic        link_req = 1'b0, sp_wr = 1'b0, exc_ret_req = 1'b0;
  logic        clr_bit0 = 1'b0, fault_cmd = 1'b0, bus_fault;
  logic [7:0]  irq_pend = 8'h00, irq_en = 8'hFF;
  logic [23:0] irq_prio = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
  logic [2:0]  prio_mask = 3'h7;
  logic [3:0]  ldm_progress = 4'h0, ldm_base_idx = 4'h0;
  logic [31:0] ldm_base_orig = 32'h0, ldm_base_new = 32'h0, ldm_base_load_val = 32'h0;
  logic [31:0] cur_pc = 32'h0, sp_wdata = 32'h0, vec_rdata;
  logic        handler_mode, irq_ack, mem_wr, mem_rd, vec_rd, fetch_req, first_instr;
  logic        state_bit, invalid_state_fault, lockup, div_abandon, div_restart;
  logic        base_reg_wr, sp_in_use;
  logic [5:0]  active_vec;
  logic [2:0]  irq_ack_idx;
  logic [3:0]  lockup_prio, continuation_progress_field;
  logic [31:0] mem_addr, vec_addr, fetch_pc, base_reg_value, main_stack_pointer;
  logic [31:0] thread_stack_pointer, link_reg, last_base = 32'h0, first_addr = 32'h0;
  logic [31:0] last_fetch = 32'h0;
  int          num_errors = 0, cmp_count = 0, seed = 68555, ops = 0, n_ab = 0, n_rs = 0;
  eeru_note_t  notes[$];
  eeru_note_t  nt;

  eeru_exc_unit DUT (.*);
  eeru_mem_model u_mem (.*);

  always #2 clk_sys = ~clk_sys;

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_hi(input logic lk);
    int n;
    n = 0;
    while ((lk ? lockup : first_instr) !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 40) begin
      num_errors++;
      tally_and_finish;
    end
  endtask

  task automatic do_reset;
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
  endtask

  // requests stay up until the handler's first instruction is seen
  task automatic step(input logic [9:0] pend, input logic [9:0] late, input logic ret,
                      input int lat, input int nops, input logic hm, input logic [5:0] vec);
    @(posedge clk_sys);
    {hard_fault_exception_req, nmi_req, irq_pend} <= {hard_fault_exception_req, nmi_req, irq_pend} | pend;
    if (ret) begin
      repeat (2) @(posedge clk_sys);
      exc_ret_req <= 1'b1;
    end
    notes.push_back('{$time, lat, nops, hm, vec, !clr_bit0});
    @(posedge clk_sys);
    exc_ret_req <= 1'b0;
    {hard_fault_exception_req, nmi_req, irq_pend} <= {hard_fault_exception_req, nmi_req, irq_pend} | late;
    wait_hi(1'b0);
    @(posedge clk_sys);
    {hard_fault_exception_req, nmi_req, irq_pend} <= {hard_fault_exception_req, nmi_req, irq_pend} & ~(pend | late);
    #1;
  endtask

  task automatic lock_case(input logic on_ret, input logic [3:0] exp);
    do_reset;
    step(10'h200, 10'h000, 1'b0, 12, 8, 1'b1, `EERU_VEC_HARD_FAULT_EXCEPTION);
    if (on_ret) step(10'h100, 10'h000, 1'b0, 12, 8, 1'b1, `EERU_VEC_NMI);
    @(posedge clk_sys);
    fault_cmd <= 1'b1;
    if (on_ret) exc_ret_req <= 1'b1;
    else nmi_req <= 1'b1;
    @(posedge clk_sys);
    exc_ret_req <= 1'b0;
    wait_hi(1'b1);
    cmp(32'(lockup_prio), 32'(exp));
    @(posedge clk_sys);
    {fault_cmd, nmi_req} <= 2'b00;
  endtask

  always @(posedge clk_sys) begin
    #1;
    if (!rst_b) ops = 0;
    else begin
      if (mem_wr === 1'b1 && ops == 0) first_addr = mem_addr;
      if (mem_wr === 1'b1 || mem_rd === 1'b1) ops++;
      if (div_abandon === 1'b1) n_ab++;
      if (div_restart === 1'b1) n_rs++;
      if (base_reg_wr === 1'b1) last_base = base_reg_value;
      if (fetch_req === 1'b1) last_fetch = fetch_pc;
      if (first_instr === 1'b1) begin
        if (notes.size() == 0) cmp(32'h1, 32'h0);
        else begin
          nt = notes.pop_front();
          cmp(32'(($time - 1 - nt.t0) / 4), 32'(nt.lat));
          cmp(32'(ops), 32'(nt.ops));
          cmp({handler_mode, state_bit, invalid_state_fault, nt.hm ? active_vec : 6'h0},
              {nt.hm, nt.sb, nt.hm & !nt.sb, nt.vec});
          cmp(last_fetch, nt.hm ? 32'(nt.vec) << 6 : cur_pc);
        end
        ops = 0;
      end
    end
  end

  initial begin
    int i;
    do_reset;
    @(posedge clk_sys);
    #1;
    cmp({state_bit, handler_mode, lockup}, 32'h4);
    @(posedge clk_sys);
    sp_wr <= 1'b1;
    sp_wdata <= 32'h20001003;
    link_req <= 1'b1;
    cur_pc <= $random(seed) & 32'hFFFFFFFE;
    div_active <= 1'b1;
    @(posedge clk_sys);
    {sp_wr, link_req} <= 2'b00;
    @(posedge clk_sys);
    #1;
    cmp(main_stack_pointer, 32'h20001000);
    cmp(link_reg, cur_pc | 32'h1);
    @(posedge clk_sys);
    {thread_psp_sel, sp_wr} <= 2'b11;
    sp_wdata <= $random(seed);
    @(posedge clk_sys);
    {thread_psp_sel, sp_wr} <= 2'b00;
    @(posedge clk_sys);
    #1;
    cmp(thread_stack_pointer, {sp_wdata[31:2], 2'b00});
    cmp(main_stack_pointer, 32'h20001000);
    i = 1 + ($unsigned($random(seed)) % 6);
    step(10'(1 << i), 10'h000, 1'b0, 12, 8, 1'b1, 6'(16 + i));
    div_active <= 1'b0;
    cmp(first_addr, 32'h20000FE0);
    cmp(link_reg, `EERU_EXC_RETURN);
    // lower priority pend at return: chain, no stacking
    step(10'h080, 10'h000, 1'b1, 6, 0, 1'b1, 6'd23);
    step(10'h000, 10'h000, 1'b1, 12, 8, 1'b0, 6'h0);
    step(10'h020, 10'h002, 1'b0, 12, 8, 1'b1, 6'd17);
    step(10'h000, 10'h000, 1'b1, 12, 8, 1'b0, 6'h0);
    clr_bit0 <= 1'b1;
    step(10'h008, 10'h000, 1'b0, 12, 8, 1'b1, 6'd19);
    // the state bit keeps the bad vector's value across the return
    step(10'h000, 10'h000, 1'b1, 12, 8, 1'b0, 6'h0);
    clr_bit0 <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      {ldm_active, ldm_writeback, thread_psp_sel} <= {1'b1, i != 3, i[0]};
      {ldm_in_if_then, ldm_faulted, ldm_base_loaded} <= {i == 1, i == 2, i == 3};
      {ldm_base_in_list, ldm_base_last} <= {i == 3, 1'b0};
      {ldm_progress, ldm_base_idx} <= 8'($random(seed));
      {ldm_base_orig, ldm_base_new} <= {$random(seed), $random(seed)};
      ldm_base_load_val <= $random(seed);
      if (i == 3) begin
        @(posedge clk_sys);
        #1;
        cmp(base_reg_value, ldm_base_load_val);
      end
      step(10'h004, 10'h000, 1'b0, 12, 8, 1'b1, 6'd18);
      cmp(32'(continuation_progress_field), 32'((i == 1 || i == 2) ? 4'h0 :
          (i == 3) ? ldm_base_idx : ldm_progress));
      if (i == 2) cmp(last_base, ldm_base_orig);
      ldm_active <= 1'b0;
      step(10'h000, 10'h000, 1'b1, 12, 8, 1'b0, 6'h0);
    end
    cmp(32'(n_ab), 32'h1);
    cmp(32'(n_rs), 32'h1);
    lock_case(1'b0, `EERU_PRIO_NMI);
    lock_case(1'b1, `EERU_PRIO_HARD_FAULT_EXCEPTION);
    tally_and_finish;
  end
endmodule
